// ===== rtl/cabx_exec.sv
// Arithmetic, logic, multiply, skip and branch execution unit
// ----------------------------------------------------------------
// Function
// [RULE1] Word add-constant adds to the 16-bit pair, sets five flags but not nibble carry, 2 cycles.
// [RULE2] AND, OR, XOR write the destination, set null/top/wrap/polarity, keep carry, 1 cycle.
// [RULE3] Multiplies put a 16-bit product in pair one:zero, six forms, only null and borrow, 2 cycles.
// [RULE4] Byte add/sub, complement, negate, inc, dec, clear, set take 1 cycle; add/sub set six flags.
// [RULE5] Equal-compare skip changes no flag and skips 1 or 2 words on equality in 1, 2 or 3 cycles.
// [RULE6] I/O bit skips test one bit and skip on clear or set, no flags, 1, 2 or 3 cycles.
// [RULE7] Signed ge branches when top xor wrap is 0, lt when 1, 1 or 2 cycles, no flags.
// [RULE8] Single flag branches load pc plus offset plus one when taken, no flags, 1 or 2 cycles.
// [RULE9] Pointer jump and call load pc 15:0 from the pointer, clear 21:16; the call takes 2/3.
// [RULE10] A branch takes one cycle when not taken and two cycles when taken.
module cabx_exec
    import cabx_pkg::*;
#(
    parameter logic [1:0] CALL_CYC = cabx_pkg::CYC_CALL
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RSTN,
    input  wire logic                  REQ_VALID,
    output logic                       REQ_READY,
    input  wire cabx_pkg::cabx_req_s   REQ,
    output logic                       DONE,
    output cabx_pkg::cabx_res_s        RES
);
    import cabx_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic cabx_alu_s alu8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin, input logic sub);
        cabx_alu_s  o;
        logic [8:0] s9;
        logic [4:0] s5;
        s9 = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                 : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
        s5 = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
                 : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
        o.r = s9[7:0];
        o.c = s9[8];
        o.h = s5[4];
        o.v = sub ? ((a[7] & ~b[7] & ~o.r[7]) | (~a[7] & b[7] & o.r[7]))
                  : ((a[7] & b[7] & ~o.r[7]) | (~a[7] & ~b[7] & o.r[7]));
        return o;
    endfunction

    function automatic logic [7:0] sign_flags(input logic [7:0] f, input logic z,
                                              input logic n, input logic v);
        logic [7:0] o;
        o                = f;
        o[FLAG_NULL]     = z;
        o[FLAG_TOP]      = n;
        o[FLAG_WRAP]     = v;
        o[FLAG_POLARITY] = n ^ v;
        return o;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    cabx_res_s   res_q;
    cabx_res_s   res_d;
    logic        acc;
    logic [15:0] mul_prod;
    logic        mul_carry;
    logic        mul_as;
    logic        mul_bs;
    logic        mul_frac;

    // Accept while idle or in the last cycle, so 1-cycle ops run back to back
    assign REQ_READY = (cnt_q <= CYC_ONE);
    assign acc       = REQ_VALID && REQ_READY;
    assign DONE      = (cnt_q == CYC_ONE);
    assign RES       = res_q;

    assign mul_as   = REQ.op inside {OP_MULSS, OP_MIXED_SIGN_PRODUCT, OP_FMULSS, OP_FRAC_PRODUCT_MIXED};
    assign mul_bs   = REQ.op inside {OP_MULSS, OP_FMULSS};
    assign mul_frac = REQ.op inside {OP_FMULUU, OP_FMULSS, OP_FRAC_PRODUCT_MIXED};

    cabx_mul u_mul (
        .a        (REQ.opa[7:0]),
        .b        (REQ.opb),
        .a_signed (mul_as),
        .b_signed (mul_bs),
        .frac     (mul_frac),
        .prod     (mul_prod),
        .carry    (mul_carry)
    );

    // ----------------------------------------------------------------
    // Result and timing of the accepted operation
    // ----------------------------------------------------------------
    always_comb begin
        cabx_alu_s   al;
        logic [16:0] w17;
        logic        cf;
        logic        take;
        logic [21:0] pc_rel;
        logic [21:0] pc_skip;
        al      = '0;
        w17     = '0;
        cf      = REQ.flags[FLAG_BORROW];
        take    = 1'b0;
        pc_rel  = REQ.pc + {{15{REQ.offset[6]}}, REQ.offset} + PC_STEP;
        pc_skip = REQ.pc + (REQ.next_long ? PC_SKIP_LONG : PC_SKIP_SHRT);
        res_d       = '0;
        res_d.flags = REQ.flags;
        res_d.pc    = REQ.pc + PC_STEP;
        cnt_d       = CYC_ONE;
        case (REQ.op)
            // Byte add and subtract set all six flags
            // [RULE4] six flag update
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_CMPC, OP_NEG: begin
                if (REQ.op == OP_NEG) begin
                    al = alu8(8'h00, REQ.opa[7:0], 1'b0, 1'b1);
                end else begin
                    al = alu8(REQ.opa[7:0], REQ.opb,
                              cf & (REQ.op inside {OP_ADDC, OP_SUBC, OP_CMPC}),
                              !(REQ.op inside {OP_ADD, OP_ADDC}));
                end
                res_d.data[7:0]           = al.r;
                res_d.reg_we              = !(REQ.op inside {OP_CMP, OP_CMPC});
                res_d.flags_we            = 1'b1;
                res_d.flags               = sign_flags(REQ.flags, al.r == 8'h00, al.r[7], al.v);
                res_d.flags[FLAG_BORROW]  = al.c;
                res_d.flags[FLAG_NIBBLE]  = al.h;
                // Subtract and compare with carry only keep or clear the null flag, never set it, so multi-byte compares chain
                if (REQ.op inside {OP_SUBC, OP_CMPC}) begin
                    res_d.flags[FLAG_NULL] = (al.r == 8'h00) & REQ.flags[FLAG_NULL];
                end
            end
            // [RULE1] word add, nibble kept
            OP_WADD, OP_WSUB: begin
                w17 = (REQ.op == OP_WADD) ? ({1'b0, REQ.opa} + {9'h000, REQ.opb})
                                          : ({1'b0, REQ.opa} - {9'h000, REQ.opb});
                res_d.data     = w17[15:0];
                res_d.pair_we  = 1'b1;
                res_d.flags_we = 1'b1;
                if (REQ.op == OP_WADD) begin
                    res_d.flags = sign_flags(REQ.flags, w17[15:0] == 16'h0000, w17[15],
                                             ~REQ.opa[15] & w17[15]);
                    res_d.flags[FLAG_BORROW] = REQ.opa[15] & ~w17[15];
                end else begin
                    res_d.flags = sign_flags(REQ.flags, w17[15:0] == 16'h0000, w17[15],
                                             REQ.opa[15] & ~w17[15]);
                    res_d.flags[FLAG_BORROW] = ~REQ.opa[15] & w17[15];
                end
                cnt_d = CYC_TWO;
            end
            // [RULE2] logic ops keep carry
            OP_AND, OP_OR, OP_XOR, OP_CLR: begin
                case (REQ.op)
                    OP_AND:  res_d.data[7:0] = REQ.opa[7:0] & REQ.opb;
                    OP_OR:   res_d.data[7:0] = REQ.opa[7:0] | REQ.opb;
                    OP_XOR:  res_d.data[7:0] = REQ.opa[7:0] ^ REQ.opb;
                    default: res_d.data[7:0] = 8'h00;
                endcase
                res_d.reg_we   = 1'b1;
                res_d.flags_we = 1'b1;
                res_d.flags    = sign_flags(REQ.flags, res_d.data[7:0] == 8'h00,
                                            res_d.data[7], 1'b0);
            end
            // [RULE4] single cycle unary ops
            OP_COM, OP_INC, OP_DEC, OP_SETR: begin
                case (REQ.op)
                    OP_COM:  al.r = ~REQ.opa[7:0];
                    OP_INC:  al = alu8(REQ.opa[7:0], 8'h01, 1'b0, 1'b0);
                    OP_DEC:  al = alu8(REQ.opa[7:0], 8'h01, 1'b0, 1'b1);
                    default: al.r = 8'hff;
                endcase
                res_d.data[7:0] = al.r;
                res_d.reg_we    = 1'b1;
                res_d.flags_we  = (REQ.op != OP_SETR);
                res_d.flags     = sign_flags(REQ.flags, al.r == 8'h00, al.r[7], al.v);
                if (REQ.op == OP_COM) begin
                    res_d.flags[FLAG_BORROW] = 1'b1;
                end
            end
            // [RULE3] product into pair one:zero
            OP_MULUU, OP_MULSS, OP_MIXED_SIGN_PRODUCT, OP_FMULUU, OP_FMULSS, OP_FRAC_PRODUCT_MIXED: begin
                res_d.data                = mul_prod;
                res_d.prod_we             = 1'b1;
                res_d.flags_we            = 1'b1;
                res_d.flags[FLAG_NULL]    = (mul_prod == 16'h0000);
                res_d.flags[FLAG_BORROW]  = mul_carry;
                cnt_d                     = CYC_TWO;
            end
            // [RULE5] [RULE6] skips leave flags alone
            OP_EQSKIP, OP_IOSKIPC, OP_IOSKIPS: begin
                case (REQ.op)
                    OP_EQSKIP:  take = (REQ.opa[7:0] == REQ.opb);
                    OP_IOSKIPC: take = !REQ.io_val[REQ.bit_sel];
                    default:    take = REQ.io_val[REQ.bit_sel];
                endcase
                res_d.pc_we = 1'b1;
                if (take) begin
                    res_d.pc = pc_skip;
                    cnt_d    = REQ.next_long ? CYC_THREE : CYC_TWO;
                end
            end
            // [RULE7] [RULE8] [RULE10] conditional branches
            OP_BRSET, OP_BRCLR, OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED: begin
                case (REQ.op)
                    OP_BRSET: take = REQ.flags[REQ.bit_sel];
                    OP_BRCLR: take = !REQ.flags[REQ.bit_sel];
                    OP_BRANCH_GE_SIGNED:  take = !(REQ.flags[FLAG_TOP] ^ REQ.flags[FLAG_WRAP]);
                    default:  take = REQ.flags[FLAG_TOP] ^ REQ.flags[FLAG_WRAP];
                endcase
                res_d.pc_we = 1'b1;
                if (take) begin
                    res_d.pc = pc_rel;
                    cnt_d    = CYC_TWO;
                end
            end
            // [RULE9] pointer jump and call
            OP_PJUMP, OP_PCALL: begin
                res_d.pc       = {6'h00, REQ.ptr};
                res_d.pc_we    = 1'b1;
                res_d.push_we  = (REQ.op == OP_PCALL);
                res_d.ret_addr = REQ.pc + PC_STEP;
                cnt_d          = (REQ.op == OP_PCALL) ? CALL_CYC : CYC_TWO;
            end
            default: begin
                res_d.pc_we = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Cycle counter
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            cnt_q <= 2'h0;
        end else if (acc) begin
            cnt_q <= cnt_d;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    // Result held until the next accept; valid while DONE is high
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            res_q <= '0;
        end else if (acc) begin
            res_q <= res_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    sequence two_cycle_s;
        !DONE ##1 DONE;
    endsequence

    sequence three_cycle_s;
        !DONE ##1 !DONE ##1 DONE;
    endsequence

    word_add_time_a: assert property ( // [RULE1]
        acc && REQ.op == OP_WADD |=> two_cycle_s and
            (res_q.pair_we && res_q.flags[FLAG_NIBBLE] == $past(REQ.flags[FLAG_NIBBLE])))
        else $error("word add timing or nibble flag wrong");

    logic_carry_a: assert property ( // [RULE2]
        acc && REQ.op inside {OP_AND, OP_OR, OP_XOR} |=> DONE && res_q.reg_we
            && res_q.flags[FLAG_BORROW] == $past(REQ.flags[FLAG_BORROW])
            && !res_q.flags[FLAG_WRAP])
        else $error("logic op changed carry or took too long");

    mul_flags_a: assert property ( // [RULE3]
        acc && REQ.op inside {OP_MULUU, OP_FMULSS} |=> two_cycle_s and
            (res_q.prod_we && res_q.flags[7:2] == $past(REQ.flags[7:2])))
        else $error("multiply timing or flags wrong");

    add_half_a: assert property ( // [RULE4]
        acc && REQ.op == OP_ADD && REQ.opa[3:0] == 4'hf && REQ.opb[3:0] == 4'h1
        |=> DONE && res_q.flags[FLAG_NIBBLE] && res_q.reg_we)
        else $error("add nibble carry missing");

    eq_skip_a: assert property ( // [RULE5]
        acc && REQ.op == OP_EQSKIP && REQ.opa[7:0] == REQ.opb && REQ.next_long
        |=> three_cycle_s and (res_q.pc == $past(REQ.pc) + PC_SKIP_LONG && !res_q.flags_we))
        else $error("equal skip pc or timing wrong");

    io_skip_a: assert property ( // [RULE6]
        acc && REQ.op == OP_IOSKIPC && REQ.io_val == 8'hff
        |=> DONE && res_q.pc == $past(REQ.pc) + PC_STEP)
        else $error("io skip taken on set bit");

    signed_branch_a: assert property ( // [RULE7]
        acc && REQ.op == OP_BRANCH_LT_SIGNED && (REQ.flags[FLAG_TOP] ^ REQ.flags[FLAG_WRAP])
        |=> two_cycle_s and (res_q.pc == $past(REQ.pc) +
            {{15{$past(REQ.offset[6])}}, $past(REQ.offset)} + PC_STEP))
        else $error("signed branch target or timing wrong");

    flag_branch_a: assert property ( // [RULE8]
        acc && REQ.op == OP_BRCLR && !REQ.flags[REQ.bit_sel]
        |=> !res_q.flags_we && res_q.pc == $past(REQ.pc) +
            {{15{$past(REQ.offset[6])}}, $past(REQ.offset)} + PC_STEP)
        else $error("flag branch target wrong");

    pointer_jump_a: assert property ( // [RULE9]
        acc && REQ.op inside {OP_PJUMP, OP_PCALL}
        |=> res_q.pc == {6'h00, $past(REQ.ptr)} && res_q.pc_we ##1 DONE)
        else $error("pointer jump target or timing wrong");

    branch_fall_a: assert property ( // [RULE10]
        acc && REQ.op == OP_BRSET && !REQ.flags[REQ.bit_sel] |=> DONE)
        else $error("untaken branch not one cycle");
endmodule

// ===== rtl/cabx_pkg.sv
// Shared types and constants for the execution block
package cabx_pkg;

    // ----------------------------------------------------------------
    // Status flag bit positions
    // ----------------------------------------------------------------
    localparam int FLAG_BORROW   = 0;
    localparam int FLAG_NULL     = 1;
    localparam int FLAG_TOP      = 2;
    localparam int FLAG_WRAP     = 3;
    localparam int FLAG_POLARITY = 4;
    localparam int FLAG_NIBBLE   = 5;

    // ----------------------------------------------------------------
    // Cycle counts and program counter steps
    // ----------------------------------------------------------------
    localparam logic [1:0]  CYC_ONE      = 2'h1;
    localparam logic [1:0]  CYC_TWO      = 2'h2;
    localparam logic [1:0]  CYC_THREE    = 2'h3;
    localparam logic [1:0]  CYC_CALL     = 2'h2;
    localparam logic [21:0] PC_STEP      = 22'h000001;
    localparam logic [21:0] PC_SKIP_SHRT = 22'h000002;
    localparam logic [21:0] PC_SKIP_LONG = 22'h000003;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD = 5'b00000, OP_ADDC = 5'b00001, OP_SUB = 5'b00010, OP_SUBC = 5'b00011,
        OP_CMP = 5'b00100, OP_CMPC = 5'b00101, OP_WADD = 5'b00110, OP_WSUB = 5'b00111,
        OP_AND = 5'b01000, OP_OR = 5'b01001, OP_XOR = 5'b01010, OP_COM = 5'b01011,
        OP_NEG = 5'b01100, OP_INC = 5'b01101, OP_DEC = 5'b01110, OP_CLR = 5'b01111,
        OP_SETR = 5'b10000, OP_MULUU = 5'b10001, OP_MULSS = 5'b10010, OP_MIXED_SIGN_PRODUCT = 5'b10011,
        OP_FMULUU = 5'b10100, OP_FMULSS = 5'b10101, OP_FRAC_PRODUCT_MIXED = 5'b10110,
        OP_EQSKIP = 5'b10111, OP_IOSKIPC = 5'b11000, OP_IOSKIPS = 5'b11001,
        OP_BRSET = 5'b11010, OP_BRCLR = 5'b11011, OP_BRANCH_GE_SIGNED = 5'b11100, OP_BRANCH_LT_SIGNED = 5'b11101,
        OP_PJUMP = 5'b11110, OP_PCALL = 5'b11111
    } cabx_op_e;

    // ----------------------------------------------------------------
    // Request from decode and answer to register file / fetch
    // ----------------------------------------------------------------
    typedef struct packed {
        cabx_op_e    op;
        logic [15:0] opa;
        logic [7:0]  opb;
        logic [7:0]  io_val;
        logic [2:0]  bit_sel;
        logic        next_long;
        logic [6:0]  offset;
        logic [15:0] ptr;
        logic [21:0] pc;
        logic [7:0]  flags;
    } cabx_req_s;

    typedef struct packed {
        logic [15:0] data;
        logic        reg_we;
        logic        pair_we;
        logic        prod_we;
        logic [7:0]  flags;
        logic        flags_we;
        logic [21:0] pc;
        logic        pc_we;
        logic        push_we;
        logic [21:0] ret_addr;
    } cabx_res_s;

    typedef struct packed {
        logic [7:0] r;
        logic       c;
        logic       h;
        logic       v;
    } cabx_alu_s;

endpackage

// ===== rtl/cabx_mul.sv
// Two-operand 8x8 multiplier with sign and fraction options
module cabx_mul (
    input  wire logic [7:0]  a,
    input  wire logic [7:0]  b,
    input  wire logic        a_signed,
    input  wire logic        b_signed,
    input  wire logic        frac,
    output logic      [15:0] prod,
    output logic             carry
);
    logic signed [8:0]  a_ext;
    logic signed [8:0]  b_ext;
    logic signed [17:0] full;
    logic        [15:0] raw;

    // Nine-bit extension covers all sign combinations with one multiplier
    assign a_ext = $signed({a_signed & a[7], a});
    assign b_ext = $signed({b_signed & b[7], b});
    assign full  = a_ext * b_ext;
    assign raw   = full[15:0];
    // Carry is the top bit before the fractional shift
    assign carry = raw[15];
    assign prod  = frac ? {raw[14:0], 1'b0} : raw;
endmodule

// ===== verification/cabx_dec_model.sv
// Decode-stage model that offers operations to the execution block
module cabx_dec_model (
    input  wire logic           clk,
    input  wire logic           ready,
    output logic                valid,
    output cabx_pkg::cabx_req_s req
);
    timeunit 1ns;
    timeprecision 1ns;
    import cabx_pkg::*;

    initial begin
        valid = 1'b0;
        req   = '0;
    end

    // ----------------------------------------------------------------
    // Offer and release
    // ----------------------------------------------------------------
    // Released fields are inverted so stale operands never look live
    task automatic drop();
        valid = 1'b0;
        req   = ~req;
    endtask

    // A gap of zero keeps valid high, giving back-to-back offers
    task automatic offer(input cabx_req_s r, input int gap);
        if (gap > 0) begin
            drop();
            repeat (gap) @(negedge clk);
        end
        valid = 1'b1;
        req   = r;
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
endmodule

// ===== verification/test_cpu_alu_branch_exec.sv
// Self-checking bench for the execution block
module test_cpu_alu_branch_exec;
    timeunit 1ns;
    timeprecision 1ns;
    import cabx_pkg::*;

    logic      sys_clk;
    logic      rstn;
    logic      req_valid;
    logic      req_ready;
    logic      done;
    cabx_req_s req;
    cabx_res_s res;
    int        num_errors;
    int        checks_done;
    int        cyc;
    int        seed;
    cabx_op_e  ops[32] = '{OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_CMPC, OP_WADD,
        OP_WSUB, OP_AND, OP_OR, OP_XOR, OP_COM,
        OP_NEG, OP_INC, OP_DEC, OP_CLR, OP_SETR, OP_MULUU, OP_MULSS, OP_MIXED_SIGN_PRODUCT, OP_FMULUU,
        OP_FMULSS, OP_FRAC_PRODUCT_MIXED, OP_EQSKIP, OP_IOSKIPC, OP_IOSKIPS, OP_BRSET, OP_BRCLR,
        OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED, OP_PJUMP, OP_PCALL};
    logic [15:0] cor_a[3] = '{16'h007f, 16'hff80, 16'hffff};
    logic [7:0]  cor_b[3] = '{8'h01, 8'h80, 8'h01};

    cabx_exec dut_u (
        .SYS_CLK   (sys_clk),
        .RSTN      (rstn),
        .REQ_VALID (req_valid),
        .REQ_READY (req_ready),
        .REQ       (req),
        .DONE      (done),
        .RES       (res)
    );

    cabx_dec_model dec_u (
        .clk   (sys_clk),
        .ready (req_ready),
        .valid (req_valid),
        .req   (req)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Ceiling well above about 1200 cycles of planned traffic
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Checking and reporting
    // ----------------------------------------------------------------
    task automatic chk(input logic [21:0] seen, input logic [21:0] want, input string what);
        checks_done = checks_done + 1;
        if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Expected answer of one operation
    // ----------------------------------------------------------------
    function automatic cabx_res_s expect_of(input cabx_req_s q, output int n, output logic fc);
        cabx_res_s   e;
        logic [7:0]  a;
        logic [7:0]  bb;
        logic [7:0]  r;
        logic [15:0] w;
        logic [4:0]  h;
        logic        c8;
        logic        sub;
        logic        ci;
        logic        sa;
        logic        sb;
        logic        tk;
        e = '0;
        a = q.opa[7:0];
        sub = q.op inside {OP_SUB, OP_SUBC, OP_CMP, OP_CMPC, OP_WSUB};
        ci = sub ^ (q.op inside {OP_ADDC, OP_SUBC, OP_CMPC} && q.flags[FLAG_BORROW]);
        bb = sub ? ~q.opb : q.opb;
        sa = q.op inside {OP_MULSS, OP_MIXED_SIGN_PRODUCT, OP_FMULSS, OP_FRAC_PRODUCT_MIXED};
        sb = q.op inside {OP_MULSS, OP_FMULSS};
        e.flags = q.flags;
        e.flags_we = 1'b1;
        e.reg_we = 1'b1;
        fc = 1'b1;
        n = 1;
        r = 8'h00;
        w = 16'h0000;
        case (q.op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP, OP_CMPC: begin
                {c8, r} = a + bb + ci;
                h = a[3:0] + bb[3:0] + ci;
                e.flags[FLAG_BORROW] = c8 ^ sub;
                e.flags[FLAG_NIBBLE] = h[4] ^ sub;
                e.flags[FLAG_WRAP] = (a[7] ~^ bb[7]) & (r[7] ^ a[7]);
                e.reg_we = !(q.op inside {OP_CMP, OP_CMPC});
            end
            OP_AND, OP_OR, OP_XOR: begin
                r = (q.op == OP_AND) ? a & q.opb : (q.op == OP_OR) ? a | q.opb : a ^ q.opb;
                e.flags[FLAG_WRAP] = 1'b0;
            end
            OP_COM, OP_NEG, OP_INC, OP_DEC, OP_CLR, OP_SETR: begin
                fc = 1'b0;
                e.flags_we = q.op != OP_SETR;
                r = (q.op == OP_COM) ? ~a : (q.op == OP_NEG) ? 8'h00 - a :
                    (q.op == OP_INC) ? a + 8'h01 : (q.op == OP_DEC) ? a - 8'h01 :
                    {8{q.op == OP_SETR}};
            end
            OP_WADD, OP_WSUB: begin
                n = 2;
                e.reg_we = 1'b0;
                e.pair_we = 1'b1;
                w = sub ? q.opa - {8'h00, q.opb} : q.opa + {8'h00, q.opb};
                e.flags[FLAG_BORROW] = (q.opa[15] ^ sub) & ~(w[15] ^ sub);
                e.flags[FLAG_WRAP] = ~(q.opa[15] ^ sub) & (w[15] ^ sub);
                e.flags[FLAG_TOP] = w[15];
                e.flags[FLAG_NULL] = w == 16'h0000;
            end
            OP_MULUU, OP_MULSS, OP_MIXED_SIGN_PRODUCT, OP_FMULUU, OP_FMULSS, OP_FRAC_PRODUCT_MIXED: begin
                n = 2;
                e.reg_we = 1'b0;
                e.prod_we = 1'b1;
                w = $signed({sa & a[7], a}) * $signed({sb & q.opb[7], q.opb});
                e.flags[FLAG_BORROW] = w[15];
                if (q.op inside {OP_FMULUU, OP_FMULSS, OP_FRAC_PRODUCT_MIXED}) w = w << 1;
                e.flags[FLAG_NULL] = w == 16'h0000;
            end
            default: begin
                e.reg_we = 1'b0;
                e.flags_we = 1'b0;
                fc = 1'b0;
                e.pc_we = 1'b1;
                case (q.op)
                    OP_EQSKIP:  tk = a == q.opb;
                    OP_IOSKIPC: tk = !q.io_val[q.bit_sel];
                    OP_IOSKIPS: tk = q.io_val[q.bit_sel];
                    OP_BRSET:   tk = q.flags[q.bit_sel];
                    OP_BRCLR:   tk = !q.flags[q.bit_sel];
                    OP_BRANCH_GE_SIGNED:    tk = !(q.flags[FLAG_TOP] ^ q.flags[FLAG_WRAP]);
                    OP_BRANCH_LT_SIGNED:    tk = q.flags[FLAG_TOP] ^ q.flags[FLAG_WRAP];
                    default:    tk = 1'b1;
                endcase
                if (q.op inside {OP_EQSKIP, OP_IOSKIPC, OP_IOSKIPS}) begin
                    n = tk ? (q.next_long ? 3 : 2) : 1;
                    e.pc = q.pc + 22'(n);
                end else if (q.op inside {OP_PJUMP, OP_PCALL}) begin
                    n = (q.op == OP_PCALL) ? int'(CYC_CALL) : 2;
                    e.pc = {6'h00, q.ptr};
                    e.push_we = q.op == OP_PCALL;
                end else begin
                    n = tk ? 2 : 1;
                    e.pc = q.pc + 22'h1 + (tk ? {{15{q.offset[6]}}, q.offset} : 22'h0);
                end
            end
        endcase
        if (q.op inside {OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR} || (sub && !e.pair_we)) begin
            e.flags[FLAG_TOP] = r[7];
            e.flags[FLAG_NULL] = r == 8'h00;
            if (q.op inside {OP_SUBC, OP_CMPC}) e.flags[FLAG_NULL] &= q.flags[FLAG_NULL];
        end
        if (fc && !e.prod_we) e.flags[FLAG_POLARITY] = e.flags[FLAG_TOP] ^ e.flags[FLAG_WRAP];
        e.data = (e.pair_we | e.prod_we) ? w : {8'h00, r};
        return e;
    endfunction

    function automatic cabx_req_s rnd_req(input cabx_op_e op);
        cabx_req_s    q;
        logic [127:0] rv;
        rv = {$random(seed), $random(seed), $random(seed), $random(seed)};
        q = rv[$bits(cabx_req_s)-1:0];
        q.op = op;
        if (rv[127]) q.opb = q.opa[7:0];
        return q;
    endfunction

    // ----------------------------------------------------------------
    // One operation: offer, then watch every cycle up to completion
    // ----------------------------------------------------------------
    task automatic run(input cabx_req_s q, input int gap);
        cabx_res_s e;
        int        n;
        logic      fc;
        if (q.op inside {OP_WADD, OP_WSUB}) q.opb[7:6] = 2'h0;
        e = expect_of(q, n, fc);
        dec_u.offer(q, gap);
        for (int k = 1; k <= n; k++) begin
            @(negedge sys_clk);
            if (k == 1 && n > 1) dec_u.drop();
            chk(done, k == n, "done");
            chk(req_ready, k == n, "ready");
        end
        chk(res.flags_we, e.flags_we, "flag write");
        chk({res.reg_we, res.pair_we, res.prod_we}, {e.reg_we, e.pair_we, e.prod_we},
            "target");
        if (e.reg_we) chk(res.data[7:0], e.data[7:0], "byte");
        if (e.pair_we || e.prod_we) chk(res.data, e.data, "word");
        if (fc) chk(res.flags, e.flags, "flags");
        chk(res.pc_we, e.pc_we, "pc write");
        if (e.pc_we) chk(res.pc, e.pc, "pc");
        chk(res.push_we, e.push_we, "push");
        if (e.push_we) chk(res.ret_addr, q.pc + 22'h1, "return");
    endtask

    initial begin
        cabx_req_s q;
        num_errors = 0;
        checks_done = 0;
        cyc = 0;
        seed = 32'h06ab;
        rstn = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk({req_ready, done}, 2'b10, "reset idle");
        rstn = 1'b1;
        // Boundary operands for every operation, prompt and slow offers
        foreach (ops[i]) begin
            for (int c = 0; c < 3; c++) begin
                q = rnd_req(ops[i]);
                q.opa = cor_a[c];
                q.opb = cor_b[c];
                q.io_val = cor_a[c][15:8];
                run(q, c);
            end
        end
        repeat (400) begin
            q = rnd_req(ops[$unsigned($random(seed)) % 32]);
            run(q, $unsigned($random(seed)) % 3);
        end
        final_report();
    end
endmodule
